// >>> verilog/charger_smbus_register_port.sv
// SMBus target port holding the charger's 16-bit setting registers
// How it works
// R01 - All registers are full 16-bit words
// R02 - Five settings accept host writes
// R03 - Host starts writes with direction bit zero
// R04 - Register address byte acknowledged; charge at 0x14
// R05 - Low byte first, each data byte acknowledged
// R06 - Host closes write with a stop
// R07 - New setting applied only at stop
// R08 - One register per write transaction
// R09 - Seven registers can be read back
// R10 - Read selects register with write, then stop
// R11 - New start, control byte with read bit
// R12 - Acknowledge read byte, send low byte
// R13 - Host acknowledges low byte on ninth clock
// R14 - High byte sent, then not-acknowledge
// R15 - Host ends read with a stop
// R16 - One register per read transaction
// R17 - Adapter current limit at 0x3F, readable
// R18 - Control register at 0x3D
// R19 - Control bits 6 and 7 ignore writes
// R20 - No refresh in 175 s cuts battery switch; the code cuts it only while the adapter flag is present
// R21 - Stray start or stop abandons transaction
`timescale 1ns/1ns
`default_nettype none
`include "charger_regs.svh"

module charger_smbus_register_port
#(
  parameter logic [6:0] TARGET_ADDR = `CHG_TARGET_ADDR,
  parameter logic [35:0] TIMEOUT_CYCLES = 36'(`CHG_TIMEOUT_CYC),
  parameter logic [15:0] MFR_ID = 16'h5A3C, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h0C17 // Arbitrary value
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // SMBus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Charger status pins
  input wire logic adapter_present_flag_in,
  input wire logic trickle_in,
  // Applied settings
  output logic [15:0] charge_current_limit_out,
  output logic [15:0] adapter_current_limit_out,
  output logic [15:0] upper_system_voltage_out,
  output logic [15:0] lower_system_voltage_out,
  output logic [15:0] control_out,
  output logic battery_switch_gate_out
);

  charger_pkg::port_state_t state_q;
  logic sda_s, scl_rise, scl_fall, start_p, stop_p;
  logic [2:0] bit_cnt_q, idx_q;
  logic rd_q, got_q, wr_done_q, tx_hi_q, ack_q, sda_oe_n_q, sda_lvl_q;
  logic [7:0] sh_q, sel_q, lo_q, hi_q;
  logic [15:0] rd_word_q, rd_word, wr_word;
  logic [15:0] charge_q, adapter_q, upper_q, lower_q, ctrl_q;
  logic adapter_s1_q, adapter_s2_q, trickle_s1_q, trickle_s2_q;
  logic [35:0] tmr_q;
  logic timed_out_q, gate_q;
  logic addr_hit, code_rd_ok, code_wr_ok, byte_ack, commit, refresh, hit;
  default clocking sys_cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  smbus_line_sync u_sync
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_level_out(sda_s),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall),
    .start_out(start_p),
    .stop_out(stop_p)
  );
  // Status pins and watchdog; a timeout set wins over a same-cycle refresh
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      adapter_s1_q <= 1'b0;
      adapter_s2_q <= 1'b0;
      trickle_s1_q <= 1'b0;
      trickle_s2_q <= 1'b0;
      sda_lvl_q <= 1'b0;
      tmr_q <= 36'd0;
      timed_out_q <= 1'b0;
      gate_q <= 1'b1;
    end
    else
    begin
      adapter_s1_q <= adapter_present_flag_in;
      adapter_s2_q <= adapter_s1_q;
      trickle_s1_q <= trickle_in;
      trickle_s2_q <= trickle_s1_q;
      sda_lvl_q <= 1'b0; // Open drain only ever pulls low
      tmr_q <= (refresh || !adapter_s2_q || hit) ? 36'd0 :
        timed_out_q ? tmr_q : tmr_q + 36'd1; // R20
      timed_out_q <= (adapter_s2_q && hit) ? 1'b1 :
        refresh ? 1'b0 : timed_out_q; // R20
      gate_q <= !(adapter_s2_q && timed_out_q); // R20
    end
  end

  // Byte decode; a fifth byte gets no acknowledge
  assign addr_hit = (sh_q[7:1] == TARGET_ADDR);
  assign code_wr_ok = (sel_q == `CHG_REG_CHARGE) || // R02
    (sel_q == `CHG_REG_ADAPTER) || (sel_q == `CHG_REG_UPPER) || // R17
    (sel_q == `CHG_REG_LOWER) || (sel_q == `CHG_REG_CTRL); // R18
  assign code_rd_ok = (sh_q == `CHG_REG_CHARGE) || // R09
    (sh_q == `CHG_REG_ADAPTER) || (sh_q == `CHG_REG_UPPER) ||
    (sh_q == `CHG_REG_LOWER) || (sh_q == `CHG_REG_CTRL) ||
    (sh_q == `CHG_REG_MFR_ID) || (sh_q == `CHG_REG_DEV_ID);
  assign byte_ack = (idx_q == 3'd0) ? addr_hit : // R04
    (idx_q == 3'd1) ? (!rd_q && code_rd_ok) : // R10
    (idx_q <= 3'd3) ? (!rd_q && code_wr_ok) : 1'b0; // R05 R08
  // Readback selection; status bits replace the stored control bits
  assign rd_word =
    (sel_q == `CHG_REG_CHARGE) ? charge_q :
    (sel_q == `CHG_REG_ADAPTER) ? adapter_q : // R17
    (sel_q == `CHG_REG_UPPER) ? upper_q :
    (sel_q == `CHG_REG_LOWER) ? lower_q :
    (sel_q == `CHG_REG_CTRL) ? (ctrl_q | {8'h00, trickle_s2_q, // R19
      adapter_s2_q, 6'h00}) :
    (sel_q == `CHG_REG_MFR_ID) ? MFR_ID : DEV_ID; // R09
  // Transfer engine; start and stop override every state
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= charger_pkg::ST_IDLE;
      bit_cnt_q <= 3'd0;
      idx_q <= 3'd0;
      rd_q <= 1'b0;
      got_q <= 1'b0;
      wr_done_q <= 1'b0;
      tx_hi_q <= 1'b0;
      ack_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      sh_q <= 8'h00;
      sel_q <= 8'h00;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      rd_word_q <= 16'h0000;
    end
    else if (start_p)
    begin
      state_q <= charger_pkg::ST_RX; // R21
      bit_cnt_q <= 3'd0;
      idx_q <= 3'd0;
      got_q <= 1'b0;
      wr_done_q <= 1'b0; // R21
      sda_oe_n_q <= 1'b1;
    end
    else if (stop_p)
    begin
      state_q <= charger_pkg::ST_IDLE;
      wr_done_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        charger_pkg::ST_RX:
        begin
          if (scl_rise)
          begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'd1;
            got_q <= (bit_cnt_q == 3'd7);
          end
          else if (scl_fall && got_q)
          begin
            got_q <= 1'b0;
            state_q <= byte_ack ? charger_pkg::ST_ACK
                                : charger_pkg::ST_IGNORE; // R08
            sda_oe_n_q <= !byte_ack; // R04 R05
            if (idx_q == 3'd0)
              rd_q <= (sh_q[0] == `CHG_DIR_READ); // R03 R11
            if (idx_q == 3'd1)
              sel_q <= sh_q;
            if (idx_q == 3'd2)
              lo_q <= sh_q; // R05
            if (idx_q == 3'd3)
              hi_q <= sh_q;
            wr_done_q <= wr_done_q || (idx_q == 3'd3); // R06
          end
        end
        charger_pkg::ST_ACK:
        begin
          if (scl_fall && rd_q)
          begin
            state_q <= charger_pkg::ST_TX; // R12
            rd_word_q <= rd_word;
            sh_q <= rd_word[7:0];
            sda_oe_n_q <= rd_word[7];
            tx_hi_q <= 1'b0;
            bit_cnt_q <= 3'd0;
          end
          else if (scl_fall)
          begin
            state_q <= charger_pkg::ST_RX;
            sda_oe_n_q <= 1'b1;
            idx_q <= idx_q + 3'd1;
          end
        end
        charger_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            bit_cnt_q <= bit_cnt_q + 3'd1;
            sh_q <= {sh_q[6:0], 1'b0};
            sda_oe_n_q <= (bit_cnt_q == 3'd7) ? 1'b1 : sh_q[6];
            if (bit_cnt_q == 3'd7)
              state_q <= charger_pkg::ST_RACK;
          end
        end
        charger_pkg::ST_RACK:
        begin
          if (scl_rise)
            ack_q <= !sda_s; // R13
          else if (scl_fall && !tx_hi_q && ack_q)
          begin
            state_q <= charger_pkg::ST_TX; // R14
            tx_hi_q <= 1'b1;
            sh_q <= rd_word_q[15:8];
            sda_oe_n_q <= rd_word_q[15];
          end
          else if (scl_fall)
            state_q <= charger_pkg::ST_IGNORE; // R16
        end
        charger_pkg::ST_IDLE,
        charger_pkg::ST_IGNORE:
          sda_oe_n_q <= 1'b1;
        default:
          state_q <= charger_pkg::ST_IDLE;
      endcase
    end
  end
  // Settings change only on a stop after a complete word
  assign wr_word = {hi_q, lo_q}; // R01
  assign commit = stop_p && wr_done_q; // R07
  assign refresh = commit && ((sel_q == `CHG_REG_CHARGE) ||
    (sel_q == `CHG_REG_UPPER)); // R20
  assign hit = (tmr_q == TIMEOUT_CYCLES - 36'd1); // R20

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      charge_q <= `CHG_RST_CHARGE;
      adapter_q <= `CHG_RST_ADAPTER;
      upper_q <= `CHG_RST_UPPER;
      lower_q <= `CHG_RST_LOWER;
      ctrl_q <= `CHG_RST_CTRL;
    end
    else if (commit)
    begin
      case (sel_q)
        `CHG_REG_CHARGE: charge_q <= wr_word; // R02
        `CHG_REG_ADAPTER: adapter_q <= wr_word; // R17
        `CHG_REG_UPPER: upper_q <= wr_word;
        `CHG_REG_LOWER: lower_q <= wr_word;
        `CHG_REG_CTRL: ctrl_q <= wr_word & ~`CHG_CTRL_RO_MASK; // R19
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Outputs taken straight from their flip-flops
  assign sda_out = sda_lvl_q;
  assign sda_oe_n_out = sda_oe_n_q;
  assign charge_current_limit_out = charge_q;
  assign adapter_current_limit_out = adapter_q;
  assign upper_system_voltage_out = upper_q;
  assign lower_system_voltage_out = lower_q;
  assign control_out = ctrl_q;
  assign battery_switch_gate_out = gate_q;

  // Checks on the transfer engine and the settings
  property p_commit_at_stop;
    $changed(charge_q) |-> $past(stop_p) && $past(wr_done_q);
  endproperty
  a_commit_at_stop: assert property (p_commit_at_stop) // R07
    else $error("charge limit changed outside a stop");
  property p_full_word;
    $changed(upper_q) |-> upper_q == $past(wr_word);
  endproperty
  a_full_word: assert property (p_full_word) // R01
    else $error("upper voltage not the received word");
  property p_status_bits_clear;
    ctrl_q[7:6] == 2'b00;
  endproperty
  a_status_bits_clear: assert property (p_status_bits_clear) // R19
    else $error("host wrote a status bit");
  property p_gate_off;
    adapter_s2_q && timed_out_q |=> !battery_switch_gate_out;
  endproperty
  a_gate_off: assert property (p_gate_off) // R20
    else $error("battery switch on after timeout");
  property p_timeout_sets;
    adapter_s2_q && hit |=> timed_out_q ##1 !battery_switch_gate_out;
  endproperty
  a_timeout_sets: assert property (p_timeout_sets) // R20
    else $error("timeout did not cut the battery switch");
  property p_abandon;
    start_p |=> state_q == charger_pkg::ST_RX && idx_q == 3'd0 &&
      !wr_done_q && sda_oe_n_out;
  endproperty
  a_abandon: assert property (p_abandon) // R21
    else $error("start did not restart the transaction");
  property p_fifth_byte_nack;
    state_q == charger_pkg::ST_RX && scl_fall && got_q && idx_q == 3'd4
      && !start_p && !stop_p |=> sda_oe_n_out[*2];
  endproperty
  a_fifth_byte_nack: assert property (p_fifth_byte_nack) // R08
    else $error("extra byte acknowledged");
  property p_tx_bit;
    state_q == charger_pkg::ST_TX |-> sda_oe_n_out == sh_q[7];
  endproperty
  a_tx_bit: assert property (p_tx_bit) // R12
    else $error("sent bit differs from shift register");
  property p_release_ack_slot;
    state_q == charger_pkg::ST_RACK |-> sda_oe_n_out;
  endproperty
  a_release_ack_slot: assert property (p_release_ack_slot) // R14
    else $error("device drove the host acknowledge slot");
  c_write: cover property (commit && sel_q == `CHG_REG_CHARGE);
  c_read_hi: cover property (state_q == charger_pkg::ST_TX && tx_hi_q);
  c_timeout: cover property ($rose(timed_out_q));

endmodule // charger_smbus_register_port

`default_nettype wire

// >>> verilog/charger_regs.svh
// Register codes, reset values, field positions and timing counts
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

// Register codes carried in the register address byte
`define CHG_REG_CHARGE 8'h14
`define CHG_REG_UPPER 8'h15
`define CHG_REG_CTRL 8'h3D
`define CHG_REG_LOWER 8'h3E
`define CHG_REG_ADAPTER 8'h3F
`define CHG_REG_MFR_ID 8'hFE
`define CHG_REG_DEV_ID 8'hFF

// Reset values of the settings
`define CHG_RST_CHARGE 16'h0000
`define CHG_RST_UPPER 16'h0000
`define CHG_RST_LOWER 16'h0000
`define CHG_RST_ADAPTER 16'h0000
`define CHG_RST_CTRL 16'h0000

// Control register status fields
`define CHG_CTRL_ADAPTER_BIT 6
`define CHG_CTRL_TRICKLE_BIT 7
`define CHG_CTRL_RO_MASK 16'h00C0

// Target address and direction bit values
`define CHG_TARGET_ADDR 7'h09
`define CHG_DIR_READ 1'h1

// Watchdog time in seconds and its cycle count at the system clock
`define CHG_TIMEOUT_S 64'h0000_0000_0000_00AF
`define CHG_SYS_CLK_HZ 64'h0000_0000_05F5_E100
`define CHG_TIMEOUT_CYC (`CHG_TIMEOUT_S * `CHG_SYS_CLK_HZ)

`endif

// >>> verilog/charger_pkg.sv
// Types shared by the charger register port
package charger_pkg;

  // Transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_RACK,
    ST_IGNORE
  } port_state_t;

endpackage

// >>> verilog/smbus_line_sync.sv
// Pin synchroniser and start, stop and clock edge detection for SMBus
`timescale 1ns/1ns
`default_nettype none

module smbus_line_sync
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Detected events
  output logic sda_level_out,
  output logic scl_rise_out,
  output logic scl_fall_out,
  output logic start_out,
  output logic stop_out
);

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  // Idle bus level is high, so stages reset high to avoid false events
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  // Events only look at the second and third stages
  assign sda_level_out = sda_s2_q;
  assign scl_rise_out = scl_s2_q & ~scl_s3_q;
  assign scl_fall_out = ~scl_s2_q & scl_s3_q;
  assign start_out = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_out = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

endmodule // smbus_line_sync

`default_nettype wire

// >>> sim/smbus_host_model.sv
// Behavioural SMBus host controller facing the charger register port
`timescale 1ns/1ns
`default_nettype none

module smbus_host_model
#(
  parameter int PHASE = 6
)
(
  // Clock
  input wire logic sys_clk_in,
  // Bus wire level and host drive
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_rel_out
);
  // Idle bus released, pull-up keeps both lines high
  initial
  begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end

  // Each phase spans several clocks so the port's sync keeps up
  task automatic hold_phase();
    repeat (PHASE) @(negedge sys_clk_in);
  endtask

  // Start, also serves as a repeated start from a low clock
  task automatic start();
    sda_rel_out = 1'b1;
    hold_phase();
    scl_out = 1'b1;
    hold_phase();
    sda_rel_out = 1'b0;
    hold_phase();
    scl_out = 1'b0;
    hold_phase();
  endtask

  // Stop closes a transaction
  task automatic stop();
    sda_rel_out = 1'b0;
    hold_phase();
    scl_out = 1'b1;
    hold_phase();
    sda_rel_out = 1'b1;
    hold_phase();
  endtask

  // Data moves mid-low so it never meets a clock edge
  task automatic bit_out(input logic b);
    sda_rel_out = b;
    hold_phase();
    scl_out = 1'b1;
    hold_phase();
    scl_out = 1'b0;
    hold_phase();
  endtask

  // Sampled at the end of the high phase
  task automatic bit_in(output logic b);
    sda_rel_out = 1'b1;
    hold_phase();
    scl_out = 1'b1;
    hold_phase();
    b = sda_in;
    scl_out = 1'b0;
    hold_phase();
  endtask

  // Byte out msb first, ninth bit gives the port's answer
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    bit_in(a);
    ack = ~a;
  endtask

  // Byte in, host answers low for more, released for last
  task automatic recv_byte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_in(b[i]);
    bit_out(~more);
  endtask
endmodule // smbus_host_model

`default_nettype wire

// >>> sim/charger_smbus_register_port_bench.sv
// Self-checking bench for the charger SMBus register port
`timescale 1ns/1ns
`default_nettype none
`include "charger_regs.svh"

module charger_smbus_register_port_bench;
  localparam logic [15:0] MFR = 16'h1E2D; // Arbitrary value
  localparam logic [15:0] DEV = 16'h0B7A; // Arbitrary value
  localparam logic [6:0] ADDR = `CHG_TARGET_ADDR;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic adapter = 1'b0;
  logic trickle = 1'b0;
  logic scl;
  logic host_rel;
  logic sda_drv;
  logic sda_oe_n;
  logic [15:0] outs [5];
  logic gate;
  logic [15:0] exp_v [5] = '{default: 16'h0000};
  logic [7:0] codes [5] = '{`CHG_REG_CHARGE, `CHG_REG_ADAPTER,
    `CHG_REG_UPPER, `CHG_REG_LOWER, `CHG_REG_CTRL};
  int n_errors = 0;
  int checks_done = 0;
  // Wired-and of host release and device pull-low
  wire logic sda = host_rel & (sda_oe_n | sda_drv);

  always #5 sys_clk = ~sys_clk;

  charger_smbus_register_port #(.TIMEOUT_CYCLES(36'd200), .MFR_ID(MFR),
    .DEV_ID(DEV)) charger_smbus_register_port_i (.sys_clk_in(sys_clk),
    .rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_n_out(sda_oe_n), .adapter_present_flag_in(adapter),
    .trickle_in(trickle), .charge_current_limit_out(outs[0]),
    .adapter_current_limit_out(outs[1]),
    .upper_system_voltage_out(outs[2]),
    .lower_system_voltage_out(outs[3]), .control_out(outs[4]),
    .battery_switch_gate_out(gate));

  smbus_host_model smbus_host_model_i (.sys_clk_in(sys_clk), .sda_in(sda),
    .scl_out(scl), .sda_rel_out(host_rel));

  // Status bits never stored from host data
  function automatic logic [15:0] exp_set(input int i);
    return (i == 4) ? (exp_v[4] & 16'hFF3F) : exp_v[i];
  endfunction

  // Control reads back the live status pins in bits 7:6
  function automatic logic [15:0] exp_rd(input int i);
    return (i == 4) ? {exp_v[4][15:8], trickle, adapter, exp_v[4][5:0]}
      : exp_v[i];
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] want,
    input string what);
    checks_done++;
    if (seen !== want)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h want %h", $time, what, seen,
        want);
    end
  endtask

  task automatic ack(input logic a, input logic w);
    chk(16'(a), 16'(w), "acknowledge");
  endtask

  // Full word write with the value held back until stop
  task automatic wr(input int i, input logic [15:0] d);
    logic a;
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, 1'b0}, a);
    ack(a, 1'b1);
    smbus_host_model_i.send_byte(codes[i], a);
    ack(a, 1'b1);
    smbus_host_model_i.send_byte(d[7:0], a);
    ack(a, 1'b1);
    smbus_host_model_i.send_byte(d[15:8], a);
    ack(a, 1'b1);
    chk(outs[i], exp_set(i), "early apply");
    smbus_host_model_i.stop();
    exp_v[i] = d;
    chk(outs[i], exp_set(i), "applied");
  endtask

  // Select by write and stop, then read one word
  task automatic rd(input logic [7:0] code, output logic [15:0] d);
    logic a;
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, 1'b0}, a);
    ack(a, 1'b1);
    smbus_host_model_i.send_byte(code, a);
    ack(a, 1'b1);
    smbus_host_model_i.stop();
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, `CHG_DIR_READ}, a);
    ack(a, 1'b1);
    smbus_host_model_i.recv_byte(1'b1, d[7:0]);
    smbus_host_model_i.recv_byte(1'b0, d[15:8]);
    smbus_host_model_i.stop();
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well past the expected run length
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    end_of_test();
  end

  // Main sequence
  initial
  begin
    logic [15:0] d;
    logic a;
    void'($urandom(84));
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (5) @(negedge sys_clk);
    for (int i = 0; i < 5; i++)
      chk(outs[i], 16'h0000, "reset value");
    chk(16'(gate), 16'h0001, "gate at reset");
    // Random words to every setting, control all ones first
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 5; i++)
      begin
        adapter = 1'($urandom);
        trickle = 1'($urandom);
        wr(i, (r == 0 && i == 4) ? 16'hFFFF : 16'($urandom));
        rd(codes[i], d);
        chk(d, exp_rd(i), "readback");
      end
    rd(`CHG_REG_MFR_ID, d);
    chk(d, MFR, "first id");
    rd(`CHG_REG_DEV_ID, d);
    chk(d, DEV, "second id");
    // Foreign address and unknown code are refused
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({7'h0A, 1'b0}, a);
    ack(a, 1'b0);
    smbus_host_model_i.stop();
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, 1'b0}, a);
    smbus_host_model_i.send_byte(8'h20, a);
    ack(a, 1'b0);
    // Repeated start after the low byte abandons the write
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, 1'b0}, a);
    smbus_host_model_i.send_byte(codes[0], a);
    smbus_host_model_i.send_byte(~exp_v[0][7:0], a);
    smbus_host_model_i.start();
    smbus_host_model_i.stop();
    chk(outs[0], exp_set(0), "abandoned write");
    // Extra byte refused; the acked word lands, the next code stays put
    d = 16'($urandom);
    smbus_host_model_i.start();
    smbus_host_model_i.send_byte({ADDR, 1'b0}, a);
    smbus_host_model_i.send_byte(codes[3], a);
    smbus_host_model_i.send_byte(d[7:0], a);
    smbus_host_model_i.send_byte(d[15:8], a);
    ack(a, 1'b1);
    smbus_host_model_i.send_byte(8'h5A, a);
    ack(a, 1'b0);
    smbus_host_model_i.stop();
    exp_v[3] = d;
    chk(outs[3], exp_set(3), "single register");
    chk(outs[1], exp_set(1), "neighbour untouched");
    // Watchdog: absent adapter keeps switch on, silence cuts it
    adapter = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(16'(gate), 16'h0001, "gate without adapter");
    wr(0, 16'($urandom));
    adapter = 1'b1;
    repeat (150) @(negedge sys_clk);
    chk(16'(gate), 16'h0001, "gate before timeout");
    repeat (100) @(negedge sys_clk);
    chk(16'(gate), 16'h0000, "gate after timeout");
    wr(2, 16'($urandom));
    chk(16'(gate), 16'h0001, "gate after refresh");
    end_of_test();
  end
endmodule // charger_smbus_register_port_bench

`default_nettype wire
